/* File: current_limit_pkg.sv */
// Shared constants and carrier types for the current-limit registers
`default_nettype none
package current_limit_pkg;

    localparam int WORD_W = 16;
    localparam int FIELD_W = 11;
    localparam int MA_W = 16;

    // Bus address: five fixed upper bits, two strap bits below
    localparam logic [4:0] SMB_ADDR_FIXED = 5'h12;

    // Command codes
    localparam logic [7:0] CMD_SYS_SIDE_ILIM = 8'h14;
    localparam logic [7:0] CMD_FWD_INPUT_ILIM = 8'h3f;

    // Field layout
    localparam int FIELD_LSB = 2;
    localparam int FIELD_MSB = 12;
    localparam logic [15:0] FIELD_MASK = 16'h1ffc;
    localparam logic [15:0] LIMIT_MAX = 16'h17c0;

    // Values after reset
    localparam logic [15:0] SYS_SIDE_ILIM_RST = 16'h05dc;
    localparam logic [15:0] FWD_INPUT_ILIM_RST = 16'h05dc;

    // Weight of field bit 0 as a left shift of the field, in mA
    localparam logic [1:0] STEP_SHIFT_NORM = 2'h2;

    // Request from the bus engine
    typedef struct packed {
        logic wrWord;
        logic rdWord;
        logic wrByte;
        logic rdByte;
        logic stop;
        logic [6:0] addr;
        logic [7:0] cmd;
        logic [15:0] data;
    } smb_req_t;

    // Answer to the bus engine
    typedef struct packed {
        logic ack;
        logic rdValid;
        logic [15:0] data;
    } smb_rsp_t;

    typedef enum logic [0:0] {
        BYTE_LOW,
        BYTE_HIGH
    } byte_state_t;

endpackage
`default_nettype wire

/* File: current_limit_registers.sv */
// Current-limit register pair behind a word-level bus engine
// Notes on behaviour
// - Write-word to command 0x14 stores the system-side limit.
// - System-side limit covers forward output and reverse input current.
// - System-side write keeps bits 12..2 only; other bits dropped.
// - Recommended resistor: one field step is 4 mA, bit 2 lowest.
// - System-side field binary weighted, each bit doubles up to bit 12.
// - System-side write above maximum stores the maximum instead.
// - Reset loads system-side limit with 0x05dc, 1.5 A.
// - Word read of 0x14 returns stored system-side content.
// - Half-value resistor doubles every system-side bit weight.
// - Reverse direction compares sensed current at double the code.
// - Write-word to command 0x3f stores the forward input limit.
// - Forward input write keeps bits 12..2 only.
// - Forward input field binary weighted, 4 mA step normally.
// - Forward input write above maximum stores the maximum.
// - Alternative input resistor doubles every forward input weight.
// - Words are 16 bits; byte transfers pair low then high.
// - Answers only 1001_0 plus strap pins caught after reset.
`timescale 1ns/1ps
`default_nettype none
module current_limit_registers
    import current_limit_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic addr_select_pin_low,
    input wire logic addr_select_pin_high,
    input wire logic sysHalfSense,
    input wire logic inHalfSense,
    input wire logic reverseDir,
    input wire smb_req_t req,
    output smb_rsp_t rsp_ff,
    output logic [WORD_W-1:0] sys_side_ilim_ff,
    output logic [WORD_W-1:0] fwd_input_ilim_ff,
    output logic [MA_W-1:0] sysLimitMa_ff,
    output logic [MA_W-1:0] fwdInLimitMa_ff
);

    logic [1:0] addrStrap_ff;
    logic strapDone_ff;
    logic addrHit;
    logic hitSys;
    logic hitFwd;
    logic [WORD_W-1:0] regRead;
    byte_state_t byteState_ff;
    byte_state_t nxt_byteState;
    logic [7:0] lowByte_ff;
    logic [7:0] lowCmd_ff;
    logic wordWrite;
    logic [7:0] wordCmd;
    logic [WORD_W-1:0] wordData;
    logic [WORD_W-1:0] nxt_sysLimit;
    logic [WORD_W-1:0] nxt_fwdLimit;
    logic [FIELD_W-1:0] sysField;
    logic [FIELD_W-1:0] fwdField;
    logic [2:0] sysShift;
    logic [2:0] fwdShift;

    // Mask to the field, then clamp to the top setting
    function automatic logic [WORD_W-1:0] clampLimit(
        input logic [WORD_W-1:0] raw
    );
        logic [WORD_W-1:0] masked;
        masked = raw & FIELD_MASK;
        if (masked > LIMIT_MAX) begin
            clampLimit = LIMIT_MAX;
        end else begin
            clampLimit = masked;
        end
    endfunction

    // Strap pins caught on the first edge after reset release
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            strapDone_ff <= 1'b0;
            addrStrap_ff <= 2'h0;
        end else if (!strapDone_ff) begin
            strapDone_ff <= 1'b1;
            addrStrap_ff <= {addr_select_pin_high, addr_select_pin_low};
        end
    end

    assign addrHit = strapDone_ff &&
        (req.addr == {SMB_ADDR_FIXED, addrStrap_ff});
    assign hitSys = addrHit && (wordCmd == CMD_SYS_SIDE_ILIM);
    assign hitFwd = addrHit && (wordCmd == CMD_FWD_INPUT_ILIM);

    // Byte pairing: low byte held, high byte completes the word
    always_comb begin
        nxt_byteState = byteState_ff;
        if (req.stop) begin
            nxt_byteState = BYTE_LOW;
        end else if (addrHit && (req.wrByte || req.rdByte)) begin
            unique case (byteState_ff)
                BYTE_LOW: begin
                    nxt_byteState = BYTE_HIGH;
                end
                BYTE_HIGH: begin
                    nxt_byteState = BYTE_LOW;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            byteState_ff <= BYTE_LOW;
        end else begin
            byteState_ff <= nxt_byteState;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            lowByte_ff <= 8'h00;
            lowCmd_ff <= 8'h00;
        end else if (addrHit && (req.wrByte || req.rdByte) &&
                     byteState_ff == BYTE_LOW) begin
            lowByte_ff <= req.data[7:0];
            lowCmd_ff <= req.cmd;
        end
    end

    // Word view of the current request
    always_comb begin
        wordWrite = req.wrWord;
        wordCmd = req.cmd;
        wordData = req.data;
        if (req.wrByte && byteState_ff == BYTE_HIGH) begin
            wordWrite = 1'b1;
            wordCmd = lowCmd_ff;
            wordData = {req.data[7:0], lowByte_ff};
        end else if (req.rdByte && byteState_ff == BYTE_HIGH) begin
            wordCmd = lowCmd_ff;
        end
    end

    assign nxt_sysLimit = clampLimit(wordData);
    assign nxt_fwdLimit = clampLimit(wordData);

    // System-side limit register
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            sys_side_ilim_ff <= SYS_SIDE_ILIM_RST;
        end else if (wordWrite && hitSys) begin
            sys_side_ilim_ff <= nxt_sysLimit;
        end
    end

    // Forward input limit register
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            fwd_input_ilim_ff <= FWD_INPUT_ILIM_RST;
        end else if (wordWrite && hitFwd) begin
            fwd_input_ilim_ff <= nxt_fwdLimit;
        end
    end

    // Read mux, unmapped commands read zero
    always_comb begin
        regRead = 16'h0000;
        if (wordCmd == CMD_SYS_SIDE_ILIM) begin
            regRead = sys_side_ilim_ff & FIELD_MASK;
        end else if (wordCmd == CMD_FWD_INPUT_ILIM) begin
            regRead = fwd_input_ilim_ff & FIELD_MASK;
        end
    end

    // Answer to the bus engine
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rsp_ff <= '0;
        end else begin
            rsp_ff.ack <= addrHit && (req.wrWord || req.rdWord ||
                req.wrByte || req.rdByte);
            rsp_ff.rdValid <= addrHit && (req.rdWord || req.rdByte);
            if (addrHit && req.rdWord) begin
                rsp_ff.data <= regRead;
            end else if (addrHit && req.rdByte) begin
                if (byteState_ff == BYTE_LOW) begin
                    rsp_ff.data <= {8'h00, regRead[7:0]};
                end else begin
                    rsp_ff.data <= {8'h00, regRead[15:8]};
                end
            end
        end
    end

    // Effective limits in mA for the sense loops
    assign sysField = sys_side_ilim_ff[FIELD_MSB:FIELD_LSB];
    assign fwdField = fwd_input_ilim_ff[FIELD_MSB:FIELD_LSB];
    assign sysShift = {1'b0, STEP_SHIFT_NORM} + {2'h0, sysHalfSense} +
        {2'h0, reverseDir};
    assign fwdShift = {1'b0, STEP_SHIFT_NORM} + {2'h0, inHalfSense};

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            sysLimitMa_ff <= 16'h0000;
            fwdInLimitMa_ff <= 16'h0000;
        end else begin
            sysLimitMa_ff <= MA_W'({5'h00, sysField} << sysShift);
            fwdInLimitMa_ff <= MA_W'({5'h00, fwdField} << fwdShift);
        end
    end

    // Checks
    AST_SYS_WRITE_STORED: assert property (@(posedge mclk)
        disable iff (sys_rst)
        (wordWrite && hitSys) |=> (sys_side_ilim_ff == $past(nxt_sysLimit)))
        else $error("system-side limit not stored");

    AST_FWD_WRITE_STORED: assert property (@(posedge mclk)
        disable iff (sys_rst)
        (wordWrite && hitFwd) |=> (fwd_input_ilim_ff == $past(nxt_fwdLimit)))
        else $error("forward input limit not stored");

    AST_UNUSED_ZERO: assert property (@(posedge mclk)
        disable iff (sys_rst)
        ((sys_side_ilim_ff & ~FIELD_MASK) == 16'h0000) &&
        ((fwd_input_ilim_ff & ~FIELD_MASK) == 16'h0000))
        else $error("unused limit bits set");

    AST_CLAMPED: assert property (@(posedge mclk)
        disable iff (sys_rst)
        (sys_side_ilim_ff <= LIMIT_MAX) && (fwd_input_ilim_ff <= LIMIT_MAX))
        else $error("limit above maximum");

    AST_OVER_MAX_WRITE: assert property (@(posedge mclk)
        disable iff (sys_rst)
        (wordWrite && hitFwd && ((wordData & FIELD_MASK) > LIMIT_MAX))
        |=> (fwd_input_ilim_ff == LIMIT_MAX))
        else $error("over-maximum write not clamped");

    AST_RESET_VALUE: assert property (@(posedge mclk)
        $fell(sys_rst) |-> (sys_side_ilim_ff == SYS_SIDE_ILIM_RST))
        else $error("reset value wrong");

    AST_READBACK: assert property (@(posedge mclk)
        disable iff (sys_rst)
        (addrHit && req.rdWord && req.cmd == CMD_SYS_SIDE_ILIM &&
         !(req.wrByte && byteState_ff == BYTE_HIGH))
        |=> (rsp_ff.rdValid && rsp_ff.data == $past(sys_side_ilim_ff)))
        else $error("readback mismatch");

    AST_ACK_ADDR: assert property (@(posedge mclk)
        disable iff (sys_rst)
        rsp_ff.ack |-> $past(req.addr[6:2] == SMB_ADDR_FIXED &&
            strapDone_ff))
        else $error("ack on foreign address");

    AST_REVERSE_DOUBLE: assert property (@(posedge mclk)
        disable iff (sys_rst)
        (reverseDir && !sysHalfSense && $stable(sys_side_ilim_ff))
        |=> (sysLimitMa_ff == MA_W'({5'h00, $past(sysField)} << 3)))
        else $error("reverse limit not doubled");

    AST_ALT_SENSE: assert property (@(posedge mclk)
        disable iff (sys_rst)
        inHalfSense |=> (fwdInLimitMa_ff == MA_W'({5'h00,
            $past(fwdField)} << 3)))
        else $error("alternative weight wrong");

    AST_BYTE_PAIR: assert property (@(posedge mclk)
        disable iff (sys_rst)
        (addrHit && req.wrByte && !req.stop && byteState_ff == BYTE_LOW)
        |=> (byteState_ff == BYTE_HIGH))
        else $error("byte pairing lost");

    AST_SYS_MASKED: assert property (@(posedge mclk)
        disable iff (sys_rst)
        (wordWrite && hitSys && ((wordData & FIELD_MASK) <= LIMIT_MAX))
        |=> (sys_side_ilim_ff == $past(wordData & FIELD_MASK)))
        else $error("system-side field bits not kept");

    AST_SYS_OVER_MAX: assert property (@(posedge mclk)
        disable iff (sys_rst)
        (wordWrite && hitSys && ((wordData & FIELD_MASK) > LIMIT_MAX))
        |=> (sys_side_ilim_ff == LIMIT_MAX))
        else $error("system-side write not clamped");

    AST_FWD_MASKED: assert property (@(posedge mclk)
        disable iff (sys_rst)
        (wordWrite && hitFwd && ((wordData & FIELD_MASK) <= LIMIT_MAX))
        |=> (fwd_input_ilim_ff == $past(wordData & FIELD_MASK)))
        else $error("forward input field bits not kept");

    AST_FWD_READBACK: assert property (@(posedge mclk)
        disable iff (sys_rst)
        (addrHit && req.rdWord && req.cmd == CMD_FWD_INPUT_ILIM)
        |=> (rsp_ff.rdValid && rsp_ff.data == $past(fwd_input_ilim_ff)))
        else $error("forward input readback mismatch");

    AST_WORD_READ_CLEAN: assert property (@(posedge mclk)
        disable iff (sys_rst)
        (rsp_ff.rdValid && $past(req.rdWord))
        |-> ((rsp_ff.data & ~FIELD_MASK) == 16'h0000))
        else $error("unused bits read back set");

    AST_SYS_BASE_STEP: assert property (@(posedge mclk)
        disable iff (sys_rst)
        (!reverseDir && !sysHalfSense)
        |=> (sysLimitMa_ff == MA_W'({5'h00, $past(sysField)} << 2)))
        else $error("system-side step weight wrong");

    AST_SYS_HALF_STEP: assert property (@(posedge mclk)
        disable iff (sys_rst)
        (sysHalfSense && !reverseDir)
        |=> (sysLimitMa_ff == MA_W'({5'h00, $past(sysField)} << 3)))
        else $error("half-value resistor weight wrong");

    AST_REVERSE_HALF: assert property (@(posedge mclk)
        disable iff (sys_rst)
        (sysHalfSense && reverseDir)
        |=> (sysLimitMa_ff == MA_W'({5'h00, $past(sysField)} << 4)))
        else $error("reverse limit with half resistor wrong");

    AST_FWD_BASE_STEP: assert property (@(posedge mclk)
        disable iff (sys_rst)
        !inHalfSense
        |=> (fwdInLimitMa_ff == MA_W'({5'h00, $past(fwdField)} << 2)))
        else $error("forward input step weight wrong");

    AST_BYTE_WORD_WRITE: assert property (@(posedge mclk)
        disable iff (sys_rst)
        (addrHit && req.wrByte && byteState_ff == BYTE_HIGH &&
         lowCmd_ff == CMD_FWD_INPUT_ILIM &&
         (({req.data[7:0], lowByte_ff} & FIELD_MASK) <= LIMIT_MAX))
        |=> (fwd_input_ilim_ff ==
            $past({req.data[7:0], lowByte_ff} & FIELD_MASK)))
        else $error("byte pair not written as one word");

    AST_BYTE_READ_HIGH: assert property (@(posedge mclk)
        disable iff (sys_rst)
        (addrHit && req.rdByte && byteState_ff == BYTE_HIGH &&
         lowCmd_ff == CMD_FWD_INPUT_ILIM)
        |=> (rsp_ff.data == {8'h00, $past(fwd_input_ilim_ff[15:8])}))
        else $error("high byte read wrong");

    AST_ACK_STRAP: assert property (@(posedge mclk)
        disable iff (sys_rst)
        rsp_ff.ack |-> ($past(req.addr[1:0]) == addrStrap_ff))
        else $error("ack on wrong strap address");

    COV_SYS_WRITE: cover property (@(posedge mclk) disable iff (sys_rst)
        wordWrite && hitSys);
    COV_CLAMP: cover property (@(posedge mclk) disable iff (sys_rst)
        wordWrite && hitFwd && ((wordData & FIELD_MASK) > LIMIT_MAX));
    COV_BYTE_WORD: cover property (@(posedge mclk) disable iff (sys_rst)
        req.wrByte && addrHit && byteState_ff == BYTE_HIGH);
    COV_REVERSE: cover property (@(posedge mclk) disable iff (sys_rst)
        reverseDir && sysHalfSense);
    COV_BYTE_READ: cover property (@(posedge mclk) disable iff (sys_rst)
        req.rdByte && addrHit && byteState_ff == BYTE_HIGH);

endmodule
`default_nettype wire

/* File: current_limit_registers_tb.sv */
// Self-checking bench for the current-limit registers
`timescale 1ns/1ps
`default_nettype none
module current_limit_registers_tb
    import current_limit_pkg::*;
();
    typedef struct packed {
        logic [7:0] cmd;
        logic [15:0] wr;
        logic [15:0] exp;
        logic half;
        logic rev;
    } row_t;
    logic mclk = 1'b0;
    logic sysRst = 1'b1;
    logic addrLow = 1'b1;
    logic addrHigh = 1'b0;
    logic sysHalf = 1'b0;
    logic inHalf = 1'b0;
    logic revDir = 1'b0;
    smb_req_t req;
    smb_rsp_t rsp;
    logic [15:0] sysWord, fwdWord, sysMa, fwdMa, rd, ma;
    logic [6:0] devAddr;
    logic ack;
    int numErrors = 0;
    int checksDone = 0;
    int sh;
    row_t rows [8] = '{
        '{8'h14, 16'hffff, 16'h17c0, 1'b0, 1'b0},
        '{8'h14, 16'h0003, 16'h0000, 1'b1, 1'b0},
        '{8'h14, 16'h17c4, 16'h17c0, 1'b1, 1'b1},
        '{8'h14, 16'ha5a6, 16'h05a4, 1'b0, 1'b1},
        '{8'h3f, 16'he007, 16'h0004, 1'b1, 1'b0},
        '{8'h3f, 16'h1800, 16'h17c0, 1'b0, 1'b0},
        '{8'h3f, 16'h0aaa, 16'h0aa8, 1'b1, 1'b1},
        '{8'h14, 16'h17c0, 16'h17c0, 1'b1, 1'b1}};

    always #20 mclk = ~mclk;

    current_limit_registers uut (.mclk(mclk), .sys_rst(sysRst),
        .addr_select_pin_low(addrLow), .addr_select_pin_high(addrHigh),
        .sysHalfSense(sysHalf), .inHalfSense(inHalf), .reverseDir(revDir),
        .req(req), .rsp_ff(rsp), .sys_side_ilim_ff(sysWord),
        .fwd_input_ilim_ff(fwdWord), .sysLimitMa_ff(sysMa),
        .fwdInLimitMa_ff(fwdMa));

    smb_host_model host (.mclk(mclk), .rsp(rsp), .req(req));

    task automatic chk(input string name, input logic [15:0] exp,
        input logic [15:0] got);
        checksDone++;
        if (got !== exp) begin
            numErrors++;
            $display("wrong value %s exp %h got %h", name, exp, got);
        end
    endtask

    task automatic testDone;
        $display("checks %0d errors %0d", checksDone, numErrors);
        if (numErrors == 0 && checksDone > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic doReset;
        sysRst <= 1'b1;
        repeat (4) @(posedge mclk);
        sysRst <= 1'b0;
        repeat (2) @(posedge mclk);
        devAddr = {SMB_ADDR_FIXED, addrHigh, addrLow};
    endtask

    initial begin
        #100000;
        numErrors++;
        $display("wrong value watchdog exp done got hang");
        testDone;
    end

    initial begin
        doReset;
        foreach (rows[i]) begin
            sysHalf <= rows[i].half;
            inHalf <= rows[i].half;
            revDir <= rows[i].rev;
            host.xfer(5'h10, devAddr, rows[i].cmd, rows[i].wr, ack, rd);
            chk("write ack", 16'h0001, {15'h0000, ack});
            host.xfer(5'h08, devAddr, rows[i].cmd, 16'h0000, ack, rd);
            chk("readback", rows[i].exp, rd);
            sh = rows[i].half;
            if (rows[i].cmd == CMD_SYS_SIDE_ILIM) begin
                sh = sh + rows[i].rev;
            end
            ma = rows[i].cmd == CMD_SYS_SIDE_ILIM ? sysMa : fwdMa;
            chk("limit mA", rows[i].exp << sh, ma);
        end
        // Odd byte dropped by stop, then a low and high byte pair
        host.xfer(5'h04, devAddr, 8'h3f, 16'h0055, ack, rd);
        host.xfer(5'h01, devAddr, 8'h3f, 16'h0000, ack, rd);
        host.xfer(5'h04, devAddr, 8'h3f, 16'h0034, ack, rd);
        host.xfer(5'h04, devAddr, 8'h3f, 16'h0012, ack, rd);
        chk("byte word", 16'h1234, fwdWord);
        host.xfer(5'h02, devAddr, 8'h3f, 16'h0000, ack, rd);
        chk("byte rd low", 16'h0034, {8'h00, rd[7:0]});
        host.xfer(5'h02, devAddr, 8'h3f, 16'h0000, ack, rd);
        chk("byte rd high", 16'h0012, {8'h00, rd[7:0]});
        // Foreign address leaves the stored word alone
        host.xfer(5'h10, devAddr ^ 7'h01, 8'h14, 16'h0100, ack, rd);
        chk("foreign ack", 16'h0000, {15'h0000, ack});
        chk("foreign word", 16'h17c0, sysWord);
        // Reset mid-run with new strap levels
        addrLow <= 1'b0;
        addrHigh <= 1'b1;
        doReset;
        chk("sys reset", 16'h05dc, sysWord);
        host.xfer(5'h10, {SMB_ADDR_FIXED, 2'h1}, 8'h14, 16'h0100, ack, rd);
        chk("old addr ack", 16'h0000, {15'h0000, ack});
        host.xfer(5'h08, devAddr, 8'h14, 16'h0000, ack, rd);
        chk("sys reset rd", 16'h05dc, rd);
        host.xfer(5'h08, devAddr, 8'h3f, 16'h0000, ack, rd);
        chk("fwd reset rd", 16'h05dc, rd);
        testDone;
    end
endmodule
`default_nettype wire

/* File: smb_host_model.sv */
// Host model issuing word and byte transfers to the limit registers
`timescale 1ns/1ps
`default_nettype none
module smb_host_model
    import current_limit_pkg::*;
(
    input wire logic mclk,
    input wire smb_rsp_t rsp,
    output var smb_req_t req
);
    initial req = '0;

    // Kind bits: wrWord, rdWord, wrByte, rdByte, stop
    task automatic xfer(input logic [4:0] kind, input logic [6:0] addr,
        input logic [7:0] cmd, input logic [15:0] data,
        output logic ack, output logic [15:0] rdata);
        ack = 1'b0;
        rdata = 16'h0000;
        @(posedge mclk);
        req <= {kind, addr, cmd, data};
        @(posedge mclk);
        req <= {5'h00, addr, cmd, data};
        for (int i = 0; i < 3 && !ack; i++) begin
            @(posedge mclk);
            ack = rsp.ack;
            rdata = rsp.data;
        end
        // Released bus shows no stale value
        req <= {5'h00, ~addr, ~cmd, ~data};
    endtask
endmodule
`default_nettype wire
